// File: pkg/port_pin_pkg.sv
// constants for the general-purpose port pin control block
// assumes an apb master with 32-bit data and word-aligned registers
`default_nettype none
package port_pin_pkg;
    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          PINS_DEFAULT  = 8;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_DIRECTION = 8'h00;
    localparam logic [7:0]  OFS_DRIVE     = 8'h04;
    localparam logic [7:0]  OFS_SAMPLED   = 8'h08;
    localparam logic [7:0]  OFS_SFIO      = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          PULLUP_OFF_BIT   = 2;
    localparam logic        PULLUP_OFF_RESET = 1'b0;
    localparam logic [7:0]  SFIO_RESET    = 8'h00;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage : port_pin_pkg
`default_nettype wire

// File: rtl/port_pin_override_control.sv
// one general-purpose port: pad control, overrides, sampling, apb registers
// assumes override signals come from the owning peripherals on clk
// assumes lowPowerInputClamp comes from the sleep controller on clk
//
// Summary of operation
// - deep sleep clamps digital input to ground
// - enabled external interrupt pins escape the clamp
// - clamped high pin sets flag on wake
// - pull-ups held off while reset active
// - pull-up override, else direction/latch/off equals 010
// - drive override, else output select enables driver
// - driven level from value override or latch
// - input gate override beats sleep state gating
// - alternate input tapped before the synchronizer
// - analog tap wired straight to the pad
// - global pull-up off disables every pull-up not under pull-up override
// - override signals come from owning peripherals
// - strobes per port, clamp and off shared
// - output select picks output or pulled input
// - pin input passes two stages before sampling
// - pins tri-stated at once on reset
//
// The implementer's own choices: register access over APB and the placing of the registers.
`default_nettype none
module port_pin_override_control #(
    parameter int PINS = port_pin_pkg::PINS_DEFAULT
) (
    input  wire logic                            clk,
    input  wire logic                            sys_rst,
    input  wire logic                            clkEn,
    // apb slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [port_pin_pkg::ADDR_W-1:0] paddr,
    input  wire logic [port_pin_pkg::DATA_W-1:0] pwdata,
    output logic                                 pready,
    output logic [port_pin_pkg::DATA_W-1:0]      prdata,
    output logic                                 pslverr,
    output logic                                 irq,
    // shared by all ports
    input  wire logic                            lowPowerInputClamp,
    input  wire logic                            globalPullupOffIn,
    output logic                                 globalPullupOff,
    // per pin overrides from peripherals
    input  wire logic [PINS-1:0]                 pullUpOverrideEnable,
    input  wire logic [PINS-1:0]                 pullUpOverrideValue,
    input  wire logic [PINS-1:0]                 driveOverrideEnable,
    input  wire logic [PINS-1:0]                 driveOverrideValue,
    input  wire logic [PINS-1:0]                 pinValueOverrideEnable,
    input  wire logic [PINS-1:0]                 pinValueOverrideValue,
    input  wire logic [PINS-1:0]                 inputGateOverrideEnable,
    input  wire logic [PINS-1:0]                 inputGateOverrideValue,
    input  wire logic [PINS-1:0]                 extIntEnable,
    output logic [PINS-1:0]                      altFuncInputTap,
    output logic [PINS-1:0]                      analogPadTap,
    // pads
    input  wire logic [PINS-1:0]                 padIn,
    output logic [PINS-1:0]                      padOut,
    output logic [PINS-1:0]                      padOe_n,
    output logic [PINS-1:0]                      pullUpEn
);
    import port_pin_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PINS-1:0]   direction;
        logic [PINS-1:0]   driveLatch;
        logic              pullupOff;
        logic [PINS-1:0]   syncFirst;
        logic [PINS-1:0]   sampled;
        logic [PINS-1:0]   sampledPrev;
        logic [PINS-1:0]   irqStatus;
        logic [PINS-1:0]   irqMask;
        logic [DATA_W-1:0] rdata;
        logic              slvErr;
    } state_type;

    state_type state_r;
    state_type state_nxt;

    logic [PINS-1:0] pullCalc;
    logic [PINS-1:0] driveEn;
    logic [PINS-1:0] driveLevel;
    logic [PINS-1:0] inputEnable;
    logic [PINS-1:0] schmittOut;
    logic [PINS-1:0] changeSeen;
    logic            setupPhase;
    logic            accessWrite;
    logic            mapped;
    logic            pullupOffAll;

    // ------------------------------------------------------------
    // per pin pad logic
    // ------------------------------------------------------------
    // override inputs are used as given; their sources own them
    assign pullupOffAll = state_r.pullupOff | globalPullupOffIn;

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            always_comb begin
                // without override, pull-up only for input with latch set and not globally off
                if (pullUpOverrideEnable[gi]) begin
                    pullCalc[gi] = pullUpOverrideValue[gi];
                end else begin
                    pullCalc[gi] = ~state_r.direction[gi] & state_r.driveLatch[gi]
                                   & ~pullupOffAll;
                end
                if (driveOverrideEnable[gi]) begin
                    driveEn[gi] = driveOverrideValue[gi];
                end else begin
                    driveEn[gi] = state_r.direction[gi];
                end
                if (pinValueOverrideEnable[gi]) begin
                    driveLevel[gi] = pinValueOverrideValue[gi];
                end else begin
                    driveLevel[gi] = state_r.driveLatch[gi];
                end
                if (inputGateOverrideEnable[gi]) begin
                    inputEnable[gi] = inputGateOverrideValue[gi];
                end else begin
                    // clamp only in deep sleep, never on armed interrupt pins
                    inputEnable[gi] = ~(lowPowerInputClamp & ~extIntEnable[gi]);
                end
            end
        end
    endgenerate

    // gating sits ahead of the schmitt stage, so the tap is unsynchronised
    assign schmittOut      = padIn & inputEnable;
    assign altFuncInputTap = schmittOut;
    assign analogPadTap    = padIn;
    // reset acts without a clock: pure gating, no flop in the path
    assign padOe_n         = ~driveEn | {PINS{sys_rst}};
    assign padOut          = driveLevel & driveEn;
    assign pullUpEn        = pullCalc & ~{PINS{sys_rst}};
    assign globalPullupOff = state_r.pullupOff;

    // ------------------------------------------------------------
    // apb slave: zero wait states, read data latched in setup
    // ------------------------------------------------------------
    assign setupPhase  = psel & ~penable;
    assign accessWrite = psel & penable & pwrite;
    // nothing here can stall, so ready is tied high
    assign pready      = 1'b1;
    assign prdata      = state_r.rdata;
    assign pslverr     = state_r.slvErr;
    assign irq         = |(state_r.irqStatus & state_r.irqMask);

    always_comb begin
        case (paddr)
            OFS_DIRECTION, OFS_DRIVE, OFS_SAMPLED,
            OFS_SFIO, OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
            default:                              mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        // two-stage sampling of the gated pin
        state_nxt.syncFirst   = schmittOut;
        state_nxt.sampled     = state_r.syncFirst;
        state_nxt.sampledPrev = state_r.sampled;
        // clamp pulls a high pin low, release makes the edge on wake
        changeSeen = state_r.sampled ^ state_r.sampledPrev;
        if (setupPhase) begin
            state_nxt.slvErr = ~mapped;
            state_nxt.rdata  = ZERO_WORD;
            case (paddr)
                OFS_DIRECTION: state_nxt.rdata[PINS-1:0] = state_r.direction;
                OFS_DRIVE:     state_nxt.rdata[PINS-1:0] = state_r.driveLatch;
                OFS_SAMPLED:   state_nxt.rdata[PINS-1:0] = state_r.sampled;
                OFS_SFIO:      state_nxt.rdata[PULLUP_OFF_BIT] = state_r.pullupOff;
                OFS_IRQ_STAT:  state_nxt.rdata[PINS-1:0] = state_r.irqStatus;
                OFS_IRQ_MASK:  state_nxt.rdata[PINS-1:0] = state_r.irqMask;
                default:       state_nxt.rdata = ZERO_WORD;
            endcase
        end
        state_nxt.irqStatus = state_r.irqStatus;
        // sampled pins are read-only: a write there falls to default
        if (accessWrite) begin
            case (paddr)
                OFS_DIRECTION: state_nxt.direction  = pwdata[PINS-1:0];
                OFS_DRIVE:     state_nxt.driveLatch = pwdata[PINS-1:0];
                OFS_SFIO:      state_nxt.pullupOff  = pwdata[PULLUP_OFF_BIT];
                OFS_IRQ_STAT:  state_nxt.irqStatus  = state_r.irqStatus & ~pwdata[PINS-1:0];
                OFS_IRQ_MASK:  state_nxt.irqMask    = pwdata[PINS-1:0];
                default:       state_nxt.irqStatus  = state_r.irqStatus;
            endcase
        end
        // a change in the clearing cycle still lands
        state_nxt.irqStatus = state_nxt.irqStatus | changeSeen;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // async so the control bits clear without a running clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r           <= '0;
            state_r.pullupOff <= PULLUP_OFF_RESET;
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reset pad checks and the analog tap check also run in reset; the rest are disabled while sys_rst is high
    a_reset_tristate: assert property (@(posedge clk) sys_rst |-> (&padOe_n))
        else $error("pad driven during reset");

    a_reset_pullup: assert property (@(posedge clk) sys_rst |-> (pullUpEn == '0))
        else $error("pull-up on during reset");

    a_pulloff_kills: assert property (@(posedge clk) disable iff (sys_rst)
        pullupOffAll |-> ((pullUpEn & ~pullUpOverrideEnable) == '0))
        else $error("pull-up on while globally disabled");

    a_pull_normal: assert property (@(posedge clk) disable iff (sys_rst)
        ((pullUpEn & ~pullUpOverrideEnable)
        == (~state_r.direction & state_r.driveLatch & {PINS{~pullupOffAll}}
            & ~pullUpOverrideEnable)))
        else $error("pull-up mismatch without override");

    a_pull_override: assert property (@(posedge clk) disable iff (sys_rst)
        ((pullUpEn & pullUpOverrideEnable) == (pullUpOverrideValue & pullUpOverrideEnable)))
        else $error("pull-up override ignored");

    a_output_nopull: assert property (@(posedge clk) disable iff (sys_rst)
        ((pullUpEn & state_r.direction & ~pullUpOverrideEnable) == '0))
        else $error("pull-up on an output pin");

    a_drive_select: assert property (@(posedge clk) disable iff (sys_rst)
        (padOe_n == ~((driveOverrideEnable & driveOverrideValue)
                    | (~driveOverrideEnable & state_r.direction))))
        else $error("driver enable mismatch");

    a_drive_level: assert property (@(posedge clk) disable iff (sys_rst)
        ((padOut & ~pinValueOverrideEnable & ~driveOverrideEnable)
        == (state_r.driveLatch & state_r.direction & ~pinValueOverrideEnable
            & ~driveOverrideEnable)))
        else $error("driven level not from latch");

    a_value_override: assert property (@(posedge clk) disable iff (sys_rst)
        ((padOut & pinValueOverrideEnable & ~padOe_n)
        == (pinValueOverrideValue & pinValueOverrideEnable & ~padOe_n)))
        else $error("value override ignored");

    a_clamp_input: assert property (@(posedge clk) disable iff (sys_rst)
        lowPowerInputClamp
        |-> ((altFuncInputTap & ~extIntEnable & ~inputGateOverrideEnable) == '0))
        else $error("input not clamped in deep sleep");

    a_armed_pass: assert property (@(posedge clk) disable iff (sys_rst)
        ((altFuncInputTap & extIntEnable & ~inputGateOverrideEnable)
        == (padIn & extIntEnable & ~inputGateOverrideEnable)))
        else $error("armed interrupt pin clamped");

    a_gate_override: assert property (@(posedge clk) disable iff (sys_rst)
        ((altFuncInputTap & inputGateOverrideEnable)
        == (padIn & inputGateOverrideEnable & inputGateOverrideValue)))
        else $error("input gate override ignored");

    // a frozen enable or a reset in the last two edges breaks the pipe
    a_sample_delay: assert property (@(posedge clk) disable iff (sys_rst)
        (clkEn && $past(clkEn) && $past(clkEn, 2) && !$past(sys_rst) && !$past(sys_rst, 2))
        |-> (state_r.sampled == $past(schmittOut, 2)))
        else $error("sampled bit not two stages behind pad");

    a_wake_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (clkEn && (state_r.sampled != state_r.sampledPrev))
        |=> ((state_r.irqStatus & $past(changeSeen)) == $past(changeSeen)))
        else $error("pin change left no flag");

    // only a one written to the status word may clear a flag
    a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        (clkEn && !(accessWrite && paddr == OFS_IRQ_STAT))
        |=> ((state_r.irqStatus & $past(state_r.irqStatus)) == $past(state_r.irqStatus)))
        else $error("flag lost without a clear");

    a_pulloff_write: assert property (@(posedge clk) disable iff (sys_rst)
        (clkEn && accessWrite && paddr == OFS_SFIO)
        |=> (state_r.pullupOff == $past(pwdata[PULLUP_OFF_BIT])))
        else $error("pull-up off bit not written");

    a_err_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
        (clkEn && setupPhase)
        |=> (pslverr == !$past(mapped)))
        else $error("error response wrong for address");

    a_analog_tap: assert property (@(posedge clk) analogPadTap == padIn)
        else $error("analog tap not on pad");

endmodule : port_pin_override_control
`default_nettype wire

// File: tb/pad_model.sv
// board side of the port pads: external drivers and a weak pull-down
// assumes active low output enable and active high pull-up enable
`default_nettype none
module pad_model #(
    parameter int PINS = 8
) (
    input  wire logic [PINS-1:0] padOut,
    input  wire logic [PINS-1:0] padOe_n,
    input  wire logic [PINS-1:0] pullUpEn,
    input  wire logic [PINS-1:0] extDrv,
    input  wire logic [PINS-1:0] extLvl,
    output logic [PINS-1:0]      padIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // released lines fall to the pull-down rather than keep the last value
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (extDrv[i]) padIn[i] = extLvl[i];
            else if (!padOe_n[i]) padIn[i] = padOut[i];
            else padIn[i] = pullUpEn[i];
        end
    end
endmodule : pad_model
`default_nettype wire

// File: tb/tb_port_pin_override_control.sv
// self-checking bench for the port pin override block
// assumes the pad model closes the loop from pad outputs to padIn
`default_nettype none
module tb_port_pin_override_control;
    timeunit 1ns;
    timeprecision 1ns;
    import port_pin_pkg::*;
    logic        clk, sysRst, clkEn, psel, penable, pwrite, pready, pslverr, irq;
    logic        clamp, gpoIn, gpo, err;
    logic [7:0]  paddr, puE, puV, ddE, ddV, pvE, pvV, igE, igV, eiE, extDrv, extLvl;
    logic [7:0]  afTap, anTap, padIn, padOut, padOe_n, pullUp;
    logic [31:0] pwdata, prdata, rd;
    int          nErrors = 0, samplesChecked = 0, cycles = 0;

    port_pin_override_control #(.PINS(8)) i_port_pin_override_control (
        .clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq), .lowPowerInputClamp(clamp), .globalPullupOffIn(gpoIn),
        .globalPullupOff(gpo), .pullUpOverrideEnable(puE), .pullUpOverrideValue(puV),
        .driveOverrideEnable(ddE), .driveOverrideValue(ddV), .pinValueOverrideEnable(pvE),
        .pinValueOverrideValue(pvV), .inputGateOverrideEnable(igE),
        .inputGateOverrideValue(igV), .extIntEnable(eiE), .altFuncInputTap(afTap),
        .analogPadTap(anTap), .padIn(padIn), .padOut(padOut), .padOe_n(padOe_n),
        .pullUpEn(pullUp));
    pad_model #(.PINS(8)) i_pad_model (.padOut(padOut), .padOe_n(padOe_n),
        .pullUpEn(pullUp), .extDrv(extDrv), .extLvl(extLvl), .padIn(padIn));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            nErrors++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checked %0d mismatched %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, ZERO_WORD);
        chk(rd, exp);
    endtask : rdc
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b1, OFS_DIRECTION, 32'h0000_000f);
        apb(1'b1, OFS_DRIVE, 32'h0000_00ff);
        @(negedge clk);
        chk(padOe_n, 8'hf0);
        chk(pullUp, 8'hf0);
        chk(padOut & ~padOe_n, 8'h0f);
        @(posedge clk);
        sysRst <= 1'b1;
        @(negedge clk);
        chk(padOe_n, 8'hff);
        chk(pullUp, 8'h00);
        @(posedge clk);
        sysRst <= 1'b0;
        rdc(OFS_DIRECTION, ZERO_WORD);
        rdc(OFS_DRIVE, ZERO_WORD);
        rdc(OFS_SFIO, ZERO_WORD);
        $display("reset test over");
    endtask : t_reset
    task automatic t_override();
        apb(1'b1, OFS_DIRECTION, 32'h0000_000f);
        apb(1'b1, OFS_DRIVE, 32'h0000_00ff);
        apb(1'b1, OFS_SFIO, 32'h0000_0004);
        @(negedge clk);
        chk(pullUp, 8'h00);
        chk(gpo, 1'b1);
        apb(1'b1, OFS_SFIO, ZERO_WORD);
        gpoIn <= 1'b1;
        @(negedge clk);
        chk(pullUp, 8'h00);
        @(posedge clk);
        gpoIn <= 1'b0;
        {puE, puV, ddE, ddV, pvE, pvV} <= 48'h8101_1810_0602;
        @(negedge clk);
        chk(pullUp, 8'h71);
        chk(padOe_n, 8'he8);
        chk(padOut & ~padOe_n, 8'h13);
        @(posedge clk);
        {puE, puV, ddE, ddV, pvE, pvV} <= '0;
        $display("override test over");
    endtask : t_override
    task automatic t_sample();
        apb(1'b1, OFS_DIRECTION, ZERO_WORD);
        extDrv <= 8'hff;
        extLvl <= 8'ha5;
        repeat (4) @(posedge clk);
        extLvl <= 8'h5a;
        @(negedge clk);
        chk(afTap, 8'h5a);
        chk(anTap, 8'h5a);
        rdc(OFS_SAMPLED, 32'h0000_00a5);
        rdc(OFS_SAMPLED, 32'h0000_005a);
        $display("sample test over");
    endtask : t_sample
    task automatic t_sleep();
        // pin1 has its interrupt on, pin2 forced on, pin3 forced off
        {extLvl, igE, igV, eiE} <= 32'hff0c_0402;
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_00ff);
        repeat (4) @(posedge clk);
        apb(1'b1, OFS_IRQ_STAT, 32'h0000_00ff);
        rdc(OFS_SAMPLED, 32'h0000_00f7);
        clamp <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(OFS_SAMPLED, 32'h0000_0006);
        rdc(OFS_IRQ_STAT, 32'h0000_00f1);
        chk(irq, 1'b1);
        apb(1'b1, OFS_IRQ_STAT, 32'h0000_00ff);
        clamp <= 1'b0;
        @(negedge clk);
        chk(irq, 1'b0);
        repeat (4) @(posedge clk);
        rdc(OFS_IRQ_STAT, 32'h0000_00f1);
        apb(1'b1, OFS_IRQ_MASK, ZERO_WORD);
        @(negedge clk);
        chk(irq, 1'b0);
        $display("sleep test over");
    endtask : t_sleep
    task automatic t_bus();
        apb(1'b1, OFS_SAMPLED, ZERO_WORD);
        chk(err, 1'b0);
        rdc(OFS_SAMPLED, 32'h0000_00f7);
        rdc(8'h18, ZERO_WORD);
        chk(err, 1'b1);
        $display("bus test over");
    endtask : t_bus
    task automatic t_enable();
        // a frozen enable must drop the write and leave the pins as inputs
        @(posedge clk);
        clkEn <= 1'b0;
        apb(1'b1, OFS_DIRECTION, 32'h0000_00ff);
        @(negedge clk);
        chk(padOe_n, 8'hff);
        @(posedge clk);
        clkEn <= 1'b1;
        rdc(OFS_DIRECTION, ZERO_WORD);
        $display("enable test over");
    endtask : t_enable

    initial begin
        {sysRst, clkEn} = 2'b11;
        {psel, penable, pwrite, clamp, gpoIn} = '0;
        {paddr, pwdata} = '0;
        {puE, puV, ddE, ddV, pvE, pvV, igE, igV, eiE, extDrv, extLvl} = '0;
        repeat (5) @(posedge clk);
        sysRst <= 1'b0;
        t_reset();
        t_override();
        t_sample();
        t_sleep();
        t_bus();
        t_enable();
        close_out();
    end
endmodule : tb_port_pin_override_control
`default_nettype wire
